//--- dv/fetch_src.sv
`default_nettype none
module fetch_src (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	output logic [31:0] o_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// one xorshift step
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		y = y ^ (y << 5);
		return y;
	endfunction
	// source of operand bytes, reseeded at 2 by reset
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_word <= 32'h0000_0002;
		end else begin
			o_word <= xorshift(o_word);
		end
	end
endmodule
`default_nettype wire

//--- dv/odf_asserts.sv
`default_nettype none
module odf_chk (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_valid,
	input wire logic [2:0] i_form,
	input wire logic [2:0] i_reg_field,
	input wire logic [1:0] i_register_pair_field,
	input wire logic [7:0] i_operand_lo,
	input wire logic [7:0] i_operand_hi,
	input wire logic [4:0] i_call_table_slot_address,
	input wire logic o_valid,
	input wire logic [7:0] o_reg_sel,
	input wire logic [3:0] o_pair_sel,
	input wire logic [15:0] o_addr,
	input wire logic o_addr_ok,
	input wire logic o_odd_fixed,
	input wire logic [15:0] o_imm,
	input wire logic [7:0] o_bit_mask
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);
	// each taken operand set shows its decode one edge later
	a_valid_follow: assert property (i_valid |=> o_valid)
		else $error("answer missing");
	a_idle_quiet: assert property (!i_valid |=> !o_valid)
		else $error("answer without request");
	a_idle_hold: assert property (!i_valid |=> $stable(o_addr) && $stable(o_imm))
		else $error("outputs moved while idle");
	a_reg_onehot: assert property (i_valid |=> o_reg_sel == (8'h01 << $past(i_reg_field)))
		else $error("register select wrong");
	a_pair_onehot: assert property (i_valid |=> o_pair_sel == (4'h1 << $past(i_register_pair_field)))
		else $error("pair select wrong");
	a_short_window: assert property (i_valid && i_form == 3'd0 |=>
		o_addr == 16'hFE00 + {8'h00, $past(i_operand_lo)} && o_addr_ok == ($past(i_operand_lo) >= 8'h20))
		else $error("short window wrong");
	a_odd_flag: assert property (i_valid && i_form[0] && !i_form[2] |=>
		o_odd_fixed == $past(i_operand_lo[0]) && !o_addr[0])
		else $error("odd fix wrong");
	a_abs_addr: assert property (i_valid && i_form == 3'd2 |=>
		o_addr == {$past(i_operand_hi), $past(i_operand_lo)} && o_addr_ok && !o_odd_fixed)
		else $error("absolute address wrong");
	a_call_slot: assert property (i_valid && i_form == 3'd4 |=>
		o_addr == 16'h0040 + {10'h000, $past(i_call_table_slot_address), 1'b0} && o_addr_ok)
		else $error("call slot wrong");
	a_bit_mask: assert property (i_valid && i_form == 3'd7 |=> o_bit_mask == (8'h01 << $past(i_operand_lo[2:0])))
		else $error("bit mask wrong");
	a_imm_word: assert property (i_valid && i_form == 3'd6 |=>
		o_imm == {$past(i_operand_hi), $past(i_operand_lo)})
		else $error("immediate word wrong");
	a_imm_byte: assert property (i_valid && i_form == 3'd5 |=> o_imm == {8'h00, $past(i_operand_lo)})
		else $error("immediate byte wrong");
	cover property (i_valid && i_form == 3'd1 && i_operand_lo[0]);
	cover property (i_valid && i_form == 3'd4);
	cover property (i_valid && i_form == 3'd0 && i_operand_lo < 8'h20);
	cover property (i_valid ##1 !i_valid);
endmodule
bind operand_field_decode odf_chk chk_u(.*);
`default_nettype wire

//--- dv/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 1'b0;
	logic i_srst = 1'b1;
	logic i_valid = 1'b0;
	logic [2:0] f = 3'h0;
	logic [2:0] rf = 3'h0;
	logic [1:0] pf = 2'h0;
	logic [7:0] lo = 8'h00;
	logic [7:0] hi = 8'h00;
	logic [4:0] cs = 5'h00;
	logic o_valid;
	logic [7:0] o_reg_sel;
	logic [3:0] o_pair_sel;
	logic [15:0] o_addr;
	logic o_addr_ok;
	logic o_odd_fixed;
	logic [15:0] o_imm;
	logic [7:0] o_bit_mask;
	logic [31:0] w;
	logic k = 1'b0;
	logic [54:0] e = 55'h0;
	logic [54:0] got;
	logic [54:0] mk;
	int failures = 0;
	int num_checks = 0;
	// all outputs in one word; address field masked for non-address forms
	assign got = {o_valid, o_reg_sel, o_pair_sel, o_addr, o_addr_ok, o_odd_fixed, o_imm, o_bit_mask};
	assign mk = {13'h0000, {16{k}}, 26'h000_0000};
	// 40 ns clock
	always #20 i_clk_sys = ~i_clk_sys;
	fetch_src src_u(.i_clk_sys(i_clk_sys), .i_srst(i_srst), .o_word(w));
	operand_field_decode dut_u(.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_valid(i_valid), .i_form(f), .i_reg_field(rf),
		.i_register_pair_field(pf), .i_operand_lo(lo), .i_operand_hi(hi), .i_call_table_slot_address(cs), .o_valid(o_valid),
		.o_reg_sel(o_reg_sel), .o_pair_sel(o_pair_sel), .o_addr(o_addr), .o_addr_ok(o_addr_ok), .o_odd_fixed(o_odd_fixed),
		.o_imm(o_imm), .o_bit_mask(o_bit_mask));
	// reference decode of one operand set
	function automatic logic [53:0] m(int f, int r, int p, int l, int h, int c);
		int a, o;
		a = f < 2 ? 32'h0000_FE00 + l : f < 4 ? h * 256 + l : 32'h0000_0040 + 2 * c;
		o = (f == 1 || f == 3) && l % 2;
		return {8'(1 << r), 4'(1 << p), 16'(a - o),
			1'(f > 1 || a >= 32'h0000_FE20 && a <= 32'h0000_FF1F), 1'(o),
			16'(f == 6 ? h * 256 + l : l), 8'(f == 7 ? 1 << l % 8 : 0)};
	endfunction
	// one mismatch line with both words
	task automatic mismatch;
		failures++;
		$display("ERROR %0t exp %h got %h", $time, e, got);
	endtask
	// compare every output field against the model
	task automatic check_all;
		num_checks++;
		if (got[54] !== e[54]) mismatch();
		num_checks++;
		if ({got[53:42], got[23:0]} !== {e[53:42], e[23:0]}) mismatch();
		num_checks++;
		if ((got[41:25] | mk[41:25]) !== (e[41:25] | mk[41:25])) mismatch();
		num_checks++;
		if (got[24] !== e[24]) mismatch();
	endtask
	// random sets driven at each rising edge, valid toggling, outputs hold when idle
	task automatic run_random(input int n);
		for (int i = 0; i < n; i++) begin
			{cs, hi, lo, pf, rf, f, i_valid} <= w[29:0];
			#1;
			check_all();
			e = i_valid ? {1'b1, m(f, rf, pf, lo, hi, cs)} : {1'b0, e[53:0]};
			k = i_valid ? f > 4 : k;
			@(posedge i_clk_sys);
		end
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// reset, random sweep, mid-run reset, second sweep
	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		run_random(3000);
		$display("random decode sweep done");
		i_srst <= 1'b1;
		i_valid <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		e = 55'h0;
		k = 1'b0;
		run_random(500);
		$display("reset and resume sweep done");
		test_done();
	end
endmodule
`default_nettype wire

//--- shared/operand_field_decode_pkg.sv
// Operation
// - register field values 0 to 7 select x, a, c, b, e, d, l and h.
// - pair field values 0 to 3 select the pairs ax, bc, de and hl.
// - short direct byte addresses only reach fe20h through ff1fh; the code adds the byte to fe00h, so only fe20h to feffh are accepted.
// - short direct word addresses cover the same window at even addresses only; the code accepts fe20h to fefeh.
// - absolute addresses span 0000h to ffffh, even only for 16-bit transfers.
// - the 5-bit call table slot selects even locations from 0040h to 007fh.
// - the bit number is a 3-bit immediate choosing one of eight bit positions.
// - immediate words are 16 bits and immediate bytes are 8 bits.
// - one instruction clock is one cycle of the processor clock.
`default_nettype none
package operand_field_decode_pkg;
	// register selects, one-hot
	typedef enum logic [7:0] {
		REG_X = 8'b0000_0001,
		REG_A = 8'b0000_0010,
		REG_C = 8'b0000_0100,
		REG_B = 8'b0000_1000,
		REG_E = 8'b0001_0000,
		REG_D = 8'b0010_0000,
		REG_L = 8'b0100_0000,
		REG_H = 8'b1000_0000
	} reg_sel_t;
	typedef enum logic [3:0] {
		PAIR_AX = 4'b0001,
		PAIR_BC = 4'b0010,
		PAIR_DE = 4'b0100,
		PAIR_HL = 4'b1000
	} pair_sel_t;
	// operand forms
	typedef enum logic [2:0] {
		FORM_SHORT_BYTE = 3'b000,
		FORM_SHORT_WORD = 3'b001,
		FORM_ABS_BYTE = 3'b010,
		FORM_ABS_WORD = 3'b011,
		FORM_CALL_TABLE = 3'b100,
		FORM_IMM_BYTE = 3'b101,
		FORM_IMM_WORD = 3'b110,
		FORM_BIT_NUM = 3'b111
	} form_t;
	localparam logic [15:0] SHORT_LO = 16'hFE20;
	localparam logic [15:0] SHORT_HI = 16'hFF1F;
	localparam logic [15:0] SHORT_BASE = 16'hFE00;
	localparam logic [15:0] CALL_LO = 16'h0040;
	localparam logic [15:0] CALL_HI = 16'h007F;
	localparam logic [15:0] RST_ADDR = 16'h0000;
	localparam logic [15:0] RST_DATA = 16'h0000;
	localparam logic [7:0] RST_SEL = 8'h00;
	localparam logic [3:0] RST_PAIR = 4'h0;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic RST_FLAG = 1'b0;
endpackage
`default_nettype wire

//--- verilog/operand_field_decode.sv
`default_nettype none
module operand_field_decode (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_valid,
	input wire logic [2:0] i_form,
	input wire logic [2:0] i_reg_field,
	input wire logic [1:0] i_register_pair_field,
	input wire logic [7:0] i_operand_lo,
	input wire logic [7:0] i_operand_hi,
	input wire logic [4:0] i_call_table_slot_address,
	output logic o_valid,
	output logic [7:0] o_reg_sel,
	output logic [3:0] o_pair_sel,
	output logic [15:0] o_addr,
	output logic o_addr_ok,
	output logic o_odd_fixed,
	output logic [15:0] o_imm,
	output logic [7:0] o_bit_mask
);

	// operand form decode, one flag per form that steers a result
	wire logic is_short_byte;
	wire logic is_short_word;
	wire logic is_abs_word;
	wire logic is_call;
	wire logic is_imm_word;
	wire logic is_bit;
	assign is_short_byte = i_form == operand_field_decode_pkg::FORM_SHORT_BYTE;
	assign is_short_word = i_form == operand_field_decode_pkg::FORM_SHORT_WORD;
	assign is_abs_word = i_form == operand_field_decode_pkg::FORM_ABS_WORD;
	assign is_call = i_form == operand_field_decode_pkg::FORM_CALL_TABLE;
	assign is_imm_word = i_form == operand_field_decode_pkg::FORM_IMM_WORD;
	assign is_bit = i_form == operand_field_decode_pkg::FORM_BIT_NUM;

	// short direct byte and short pair forms share the page decode
	wire logic is_short;
	assign is_short = is_short_byte | is_short_word;

	// even-only forms: short pair and absolute word transfers
	wire logic even_only;
	assign even_only = is_short_word | is_abs_word;

	// register field to one-hot select, bit 0 is x and bit 7 is h
	wire logic [7:0] reg_sel_w;
	assign reg_sel_w = 8'h01 << i_reg_field;

	// pair field to one-hot select, bit 0 is ax and bit 3 is hl
	wire logic [3:0] pair_sel_w;
	assign pair_sel_w = 4'h1 << i_register_pair_field;

	// short direct: offset byte placed on the fe00h page
	wire logic [15:0] short_offset_w;
	wire logic [16:0] short_sum_w;
	wire logic [15:0] short_raw_w;
	assign short_offset_w = {8'h00, i_operand_lo};
	assign short_sum_w = {1'b0, operand_field_decode_pkg::SHORT_BASE} + {1'b0, short_offset_w};
	// the page base plus one byte never carries out, the top bit is dropped on purpose
	assign short_raw_w = short_sum_w[15:0];

	// window check: offsets below 20h land under the window and are refused
	wire logic short_above_lo_w;
	wire logic short_below_hi_w;
	wire logic short_in_w;
	assign short_above_lo_w = short_raw_w >= operand_field_decode_pkg::SHORT_LO;
	assign short_below_hi_w = short_raw_w <= operand_field_decode_pkg::SHORT_HI;
	assign short_in_w = short_above_lo_w & short_below_hi_w;

	// absolute address: high byte above low byte, whole 64k space
	wire logic [15:0] absolute_full_address;
	assign absolute_full_address = {i_operand_hi, i_operand_lo};

	// call table slot: doubled slot number above 0040h, always even
	wire logic [15:0] call_offset_w;
	wire logic [16:0] call_sum_w;
	wire logic [15:0] call_addr_w;
	assign call_offset_w = {10'h000, i_call_table_slot_address, 1'b0};
	assign call_sum_w = {1'b0, operand_field_decode_pkg::CALL_LO} + {1'b0, call_offset_w};
	assign call_addr_w = call_sum_w[15:0];

	// slot range check, kept so a wider slot field would be caught
	wire logic call_above_lo_w;
	wire logic call_below_hi_w;
	wire logic call_in_w;
	assign call_above_lo_w = call_addr_w >= operand_field_decode_pkg::CALL_LO;
	assign call_below_hi_w = call_addr_w <= operand_field_decode_pkg::CALL_HI;
	assign call_in_w = call_above_lo_w & call_below_hi_w;

	// address select per form, non-address forms show the absolute bytes
	wire logic [15:0] addr_raw_w;
	assign addr_raw_w = is_call ? call_addr_w : is_short ? short_raw_w : absolute_full_address;

	// odd address on an even-only form: bit 0 forced low and flagged
	wire logic odd_w;
	wire logic [15:0] addr_w;
	assign odd_w = even_only & addr_raw_w[0];
	assign addr_w = {addr_raw_w[15:1], addr_raw_w[0] & ~even_only};

	// range verdict: short forms must stay in the window after the fix-up
	wire logic short_ok_w;
	wire logic addr_ok_w;
	assign short_ok_w = short_in_w & (addr_w >= operand_field_decode_pkg::SHORT_LO);
	assign addr_ok_w = is_short ? short_ok_w : is_call ? call_in_w : 1'b1;

	// immediate sizing: word takes both bytes, byte is zero extended
	wire logic [15:0] imm_word_w;
	wire logic [15:0] imm_byte_w;
	wire logic [15:0] imm_w;
	assign imm_word_w = {i_operand_hi, i_operand_lo};
	assign imm_byte_w = {8'h00, i_operand_lo};
	assign imm_w = is_imm_word ? imm_word_w : imm_byte_w;

	// bit number: low three bits of the operand pick one bit of eight
	wire logic [2:0] bit_num_w;
	wire logic [7:0] bit_mask_w;
	wire logic [7:0] bit_mask_sel_w;
	assign bit_num_w = i_operand_lo[2:0];
	assign bit_mask_w = 8'h01 << bit_num_w;
	// other forms show an empty mask so a stale bit is never applied
	assign bit_mask_sel_w = is_bit ? bit_mask_w : operand_field_decode_pkg::RST_MASK;

	// one operand set is taken per processor clock
	wire logic load_w;
	assign load_w = i_valid;

	// answer strobe, one clock after the operand set is taken
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_valid <= 1'b0;
		end else begin
			o_valid <= load_w;
		end
	end

	// register select, held until the next operand set
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_reg_sel <= operand_field_decode_pkg::RST_SEL;
		end else if (load_w) begin
			o_reg_sel <= reg_sel_w;
		end
	end

	// register pair select, held until the next operand set
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_pair_sel <= operand_field_decode_pkg::RST_PAIR;
		end else if (load_w) begin
			o_pair_sel <= pair_sel_w;
		end
	end

	// resolved data address
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_addr <= operand_field_decode_pkg::RST_ADDR;
		end else if (load_w) begin
			o_addr <= addr_w;
		end
	end

	// range verdict travels with the address
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_addr_ok <= operand_field_decode_pkg::RST_FLAG;
		end else if (load_w) begin
			o_addr_ok <= addr_ok_w;
		end
	end

	// odd fix-up flag, so the core can trap a misaligned word access
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_odd_fixed <= operand_field_decode_pkg::RST_FLAG;
		end else if (load_w) begin
			o_odd_fixed <= odd_w;
		end
	end

	// sized immediate
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_imm <= operand_field_decode_pkg::RST_DATA;
		end else if (load_w) begin
			o_imm <= imm_w;
		end
	end

	// bit position mask
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_bit_mask <= operand_field_decode_pkg::RST_MASK;
		end else if (load_w) begin
			o_bit_mask <= bit_mask_sel_w;
		end
	end

endmodule
`default_nettype wire
